// File: design/azc_defines.svh
// Purpose: Constants for the amplifier offset and auto-zero controller
// Assumes: 20 MHz system clock
// Notes: Times in their own unit, cycle counts derived from them
`ifndef AZC_DEFINES_SVH
`define AZC_DEFINES_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define AZC_CLK_NS 50
`define AZC_SPC_US 100
`define AZC_NORM_US 200
`define AZC_DUR_NS 1000
`define AZC_TOUT_US 400
// Least times round up
`define AZC_SPC_CYC ((`AZC_SPC_US * 1000 + `AZC_CLK_NS - 1) / `AZC_CLK_NS)
`define AZC_NORM_CYC ((`AZC_NORM_US * 1000 + `AZC_CLK_NS - 1) / `AZC_CLK_NS)
`define AZC_DUR_CYC ((`AZC_DUR_NS + `AZC_CLK_NS - 1) / `AZC_CLK_NS)
`define AZC_TOUT_CYC ((`AZC_TOUT_US * 1000) / `AZC_CLK_NS)
// ----------------------------------------
// Register map
// ----------------------------------------
`define AZC_CTRL_OFS 4'h0
`define AZC_STAT_OFS 4'h4
`define AZC_CTRL_RST 4'h0
`define AZC_CAL_BIT 0
`define AZC_AZDIS_BIT 1
`define AZC_EXT_BIT 2
`define AZC_ENH_BIT 3
`endif

// File: design/azc_pkg.sv
// Purpose: Types for the amplifier offset and auto-zero controller
// Assumes: Constants come from azc_defines.svh
// Notes: Struct bit order matches the control register layout
package azc_pkg;
    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_AZ = 2'b10
    } az_state_t;

    // Control register, bit 0 lowest
    typedef struct packed {
        logic enh_sense;
        logic ext_trig;
        logic autozero_disable;
        logic cal_req;
    } ctrl_t;

    // Status register, bit 0 lowest
    typedef struct packed {
        logic uv_fault;
        logic cp_gated;
        logic az_busy;
        logic cal_on;
    } stat_t;
endpackage : azc_pkg

// File: design/amp_offset_autozero_ctrl.sv
// Purpose: DC calibration and auto-zero sequencing of three sense amplifiers
// Assumes: All inputs synchronous to CLK_SYS_I; device state given as inputs
// Notes: One sequencer serves all three amplifiers
// How it works
// R01 - Calibration is entered only in the active state with drive enable high, and shorts the inputs.
// R02 - Software writing the calibration bit to zero ends calibration and reconnects the inputs.
// R03 - During calibration in internal mode with auto-zero on, auto-zero repeats every 100us instead of on gate edges or the 400us timeout.
// R04 - Each auto-zero shorts the inputs for a fixed time while the outputs hold their last level.
// R05 - The auto-zero disable bit blocks every new auto-zero start; an auto-zero already running finishes.
// R06 - Internal mode starts auto-zero on the first gate rising edge at least 100us after the last.
// R07 - During start-up auto-zero runs on its own until the charge pump leaves undervoltage.
// R08 - Without a gate edge inside the timeout a watchdog forces an auto-zero.
// R09 - Auto-zero keeps running in the standby state.
// R10 - External mode ignores gate edges and starts auto-zero on each sync pin falling edge.
// R11 - Enhanced sensing in external mode gates the pump clock from sync rise to the end of the next auto-zero.
// R12 - Both pump rail undervoltage protections stay active while the clock is gated.
// R13 - Software should calibrate before PWM at zero current and subtract the offset itself.
// R14 - Spacing and timeout timers restart at the end of every auto-zero.
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`include "azc_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module amp_offset_autozero_ctrl #(
    parameter int SPC_CYC = `AZC_SPC_CYC,
    parameter int NORM_CYC = `AZC_NORM_CYC,
    parameter int DUR_CYC = `AZC_DUR_CYC,
    parameter int TOUT_CYC = `AZC_TOUT_CYC
) (
    input wire logic CLK_SYS_I,
    input wire logic RESETN_I,
    input wire logic [3:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RDATA_O,
    input wire logic DRIVE_EN_I,
    input wire logic STATE_ACTIVE_I,
    input wire logic STATE_STANDBY_I,
    input wire logic CP_UV_OK_I,
    input wire logic [2:0] GATE_HS_I,
    input wire logic SYNC_PIN_I,
    input wire logic LS_RAIL_UV_I,
    input wire logic HS_RAIL_UV_I,
    output logic AMP_SHORT_O,
    output logic AMP_HOLD_O,
    output logic CP_CLK_GATE_O,
    output logic UV_FAULT_O
);
    // ----------------------------------------
    // Parameter checks
    // ----------------------------------------
    generate
        if (DUR_CYC < 1 || SPC_CYC < 1 || NORM_CYC < SPC_CYC ||
            TOUT_CYC < NORM_CYC || TOUT_CYC > 65535) begin : g_bad
            $error("amp_offset_autozero_ctrl: bad timing parameters");
        end
    endgenerate

    localparam logic [15:0] SPC_L = 16'(SPC_CYC);
    localparam logic [15:0] NORM_L = 16'(NORM_CYC);
    localparam logic [15:0] TOUT_L = 16'(TOUT_CYC);
    localparam logic [15:0] DUR_L = 16'(DUR_CYC - 1);

    azc_pkg::ctrl_t ctrl_ff, nxt_ctrl;
    azc_pkg::az_state_t st_ff, nxt_st;
    logic cal_ff, nxt_cal;
    logic [15:0] since_ff, nxt_since;
    logic [15:0] dur_ff, nxt_dur;
    logic [2:0] gate_q_ff;
    logic sync_q_ff;
    logic gate_ff, nxt_gate;
    logic pend_ff, nxt_pend;
    logic [31:0] nxt_rdata;
    logic [2:0] gate_rise;
    logic sync_fall, sync_rise, startup, az_en, start, az_end;

    // ----------------------------------------
    // Edge detection
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_edge
            assign gate_rise[g] = GATE_HS_I[g] & ~gate_q_ff[g];
        end
    endgenerate
    assign sync_fall = ~SYNC_PIN_I & sync_q_ff;
    assign sync_rise = SYNC_PIN_I & ~sync_q_ff;

    // Start-up window: drive enabled, pump not yet out of undervoltage
    assign startup = DRIVE_EN_I & ~CP_UV_OK_I & ~STATE_ACTIVE_I & ~STATE_STANDBY_I;
    // R05 - disable blocks new starts
    // R09 - standby keeps running
    assign az_en = ~ctrl_ff.autozero_disable & (startup | STATE_ACTIVE_I | STATE_STANDBY_I);
    assign az_end = (st_ff == azc_pkg::ST_AZ) && (dur_ff == DUR_L);

    // ----------------------------------------
    // Trigger selection
    // ----------------------------------------
    always_comb begin
        start = 1'b0;
        if (az_en && st_ff == azc_pkg::ST_IDLE) begin
            if (ctrl_ff.ext_trig) begin
                // R10 - sync fall trigger
                start = sync_fall;
            end else if (cal_ff) begin
                // R03 - calibration 100us rate
                start = (since_ff >= SPC_L);
            end else if (startup) begin
                // R07 - start-up auto-zero
                start = (since_ff >= NORM_L);
            end else begin
                // R06 - spaced gate edge
                // R08 - timeout watchdog
                start = ((|gate_rise) && since_ff >= SPC_L) || (since_ff >= TOUT_L);
            end
        end
    end

    // ----------------------------------------
    // Sequencer next state
    // ----------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_dur = dur_ff;
        nxt_since = since_ff;
        unique case (st_ff)
            azc_pkg::ST_IDLE: begin
                if (start) begin
                    nxt_st = azc_pkg::ST_AZ;
                    nxt_dur = 16'h0000;
                end
                if (since_ff != TOUT_L) begin
                    nxt_since = since_ff + 16'h0001;
                end
            end
            azc_pkg::ST_AZ: begin
                // R04 - fixed short duration
                if (az_end) begin
                    nxt_st = azc_pkg::ST_IDLE;
                    // R14 - timers restart
                    nxt_since = 16'h0000;
                end else begin
                    nxt_dur = dur_ff + 16'h0001;
                end
            end
        endcase
    end

    // ----------------------------------------
    // Register writes and calibration
    // ----------------------------------------
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_cal = cal_ff & STATE_ACTIVE_I & DRIVE_EN_I;
        if (WR_I && ADDR_I == `AZC_CTRL_OFS) begin
            nxt_ctrl = azc_pkg::ctrl_t'(WDATA_I[3:0]);
            // R01 - entry only when active
            // R02 - write zero ends
            nxt_cal = WDATA_I[`AZC_CAL_BIT] & STATE_ACTIVE_I & DRIVE_EN_I;
        end
    end

    // ----------------------------------------
    // Pump clock gating
    // ----------------------------------------
    always_comb begin
        nxt_gate = gate_ff;
        nxt_pend = pend_ff;
        if (!(ctrl_ff.enh_sense && ctrl_ff.ext_trig)) begin
            nxt_gate = 1'b0;
            nxt_pend = 1'b0;
        end else begin
            // R11 - release at auto-zero end, before a new rise can re-gate
            if (pend_ff && az_end) begin
                nxt_gate = 1'b0;
                nxt_pend = 1'b0;
            end
            // R11 - gate from sync rise
            if (sync_rise) begin
                nxt_gate = 1'b1;
                nxt_pend = 1'b0;
            end
            if (gate_ff && sync_fall) begin
                if (start) begin
                    nxt_pend = 1'b1;
                end else begin
                    nxt_gate = 1'b0;
                end
            end
        end
    end

    // Read mux, unmapped reads zero
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (RD_I && ADDR_I == `AZC_CTRL_OFS) begin
            nxt_rdata[3:0] = {ctrl_ff.enh_sense, ctrl_ff.ext_trig, ctrl_ff.autozero_disable, cal_ff};
        end else if (RD_I && ADDR_I == `AZC_STAT_OFS) begin
            nxt_rdata[3:0] = azc_pkg::stat_t'({UV_FAULT_O, gate_ff,
                                               st_ff == azc_pkg::ST_AZ, cal_ff});
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ctrl_ff <= azc_pkg::ctrl_t'(`AZC_CTRL_RST);
            st_ff <= azc_pkg::ST_IDLE;
            cal_ff <= 1'b0;
            since_ff <= 16'h0000;
            dur_ff <= 16'h0000;
            gate_q_ff <= 3'h0;
            sync_q_ff <= 1'b0;
            gate_ff <= 1'b0;
            pend_ff <= 1'b0;
            RDATA_O <= 32'h0000_0000;
            AMP_SHORT_O <= 1'b0;
            AMP_HOLD_O <= 1'b0;
            CP_CLK_GATE_O <= 1'b0;
            UV_FAULT_O <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            st_ff <= nxt_st;
            cal_ff <= nxt_cal;
            since_ff <= nxt_since;
            dur_ff <= nxt_dur;
            gate_q_ff <= GATE_HS_I;
            sync_q_ff <= SYNC_PIN_I;
            gate_ff <= nxt_gate;
            pend_ff <= nxt_pend;
            RDATA_O <= nxt_rdata;
            // R01 - calibration shorts inputs
            // R04 - auto-zero shorts and holds
            AMP_SHORT_O <= nxt_cal | (nxt_st == azc_pkg::ST_AZ);
            AMP_HOLD_O <= (nxt_st == azc_pkg::ST_AZ);
            CP_CLK_GATE_O <= nxt_gate;
            // R12 - rail protection never gated
            UV_FAULT_O <= LS_RAIL_UV_I | HS_RAIL_UV_I;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_cal_entry;
        @(posedge CLK_SYS_I) disable iff (!RESETN_I)
        $rose(cal_ff) |-> $past(STATE_ACTIVE_I && DRIVE_EN_I && WR_I);
    endproperty
    a_cal_entry: assert property (p_cal_entry) else $error("cal entered outside active"); // R01

    property p_cal_exit;
        @(posedge CLK_SYS_I) disable iff (!RESETN_I)
        WR_I && ADDR_I == `AZC_CTRL_OFS && !WDATA_I[0] |=> !cal_ff;
    endproperty
    a_cal_exit: assert property (p_cal_exit) else $error("cal not ended by write"); // R02

    property p_cal_rate;
        @(posedge CLK_SYS_I) disable iff (!RESETN_I)
        az_en && st_ff == azc_pkg::ST_IDLE && cal_ff && !ctrl_ff.ext_trig && since_ff >= SPC_L
        |=> AMP_HOLD_O;
    endproperty
    a_cal_rate: assert property (p_cal_rate) else $error("cal auto-zero rate wrong"); // R03

    property p_az_len;
        @(posedge CLK_SYS_I) disable iff (!RESETN_I)
        $fell(AMP_HOLD_O) |-> $past(dur_ff) == DUR_L && AMP_SHORT_O == cal_ff;
    endproperty
    a_az_len: assert property (p_az_len) else $error("auto-zero length wrong"); // R04

    property p_autozero_disable;
        @(posedge CLK_SYS_I) disable iff (!RESETN_I)
        $rose(AMP_HOLD_O) |-> !$past(ctrl_ff.autozero_disable);
    endproperty
    a_autozero_disable: assert property (p_autozero_disable) else $error("auto-zero while disabled"); // R05

    property p_spacing;
        @(posedge CLK_SYS_I) disable iff (!RESETN_I)
        $rose(AMP_HOLD_O) && !$past(ctrl_ff.ext_trig) |-> $past(since_ff) >= SPC_L;
    endproperty
    a_spacing: assert property (p_spacing) else $error("auto-zero too close"); // R06

    property p_tout;
        @(posedge CLK_SYS_I) disable iff (!RESETN_I)
        az_en && st_ff == azc_pkg::ST_IDLE && !ctrl_ff.ext_trig && since_ff == TOUT_L
        |=> AMP_HOLD_O;
    endproperty
    a_tout: assert property (p_tout) else $error("timeout did not force"); // R08

    property p_ext;
        @(posedge CLK_SYS_I) disable iff (!RESETN_I)
        $rose(AMP_HOLD_O) && $past(ctrl_ff.ext_trig) |-> $past(sync_fall);
    endproperty
    a_ext: assert property (p_ext) else $error("external start without sync fall"); // R10

    property p_gate;
        @(posedge CLK_SYS_I) disable iff (!RESETN_I)
        sync_rise && ctrl_ff.enh_sense && ctrl_ff.ext_trig |=> CP_CLK_GATE_O;
    endproperty
    a_gate: assert property (p_gate) else $error("pump clock not gated"); // R11

    property p_uv;
        @(posedge CLK_SYS_I) disable iff (!RESETN_I)
        (LS_RAIL_UV_I || HS_RAIL_UV_I) |=> UV_FAULT_O;
    endproperty
    a_uv: assert property (p_uv) else $error("rail undervoltage lost"); // R12

    property p_restart;
        @(posedge CLK_SYS_I) disable iff (!RESETN_I)
        $fell(AMP_HOLD_O) |-> since_ff == 16'h0000;
    endproperty
    a_restart: assert property (p_restart) else $error("timers not restarted"); // R14

    c_edge: cover property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
        $rose(AMP_HOLD_O) && $past(|gate_rise));
    c_ext: cover property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
        $rose(AMP_HOLD_O) && $past(sync_fall));
    c_gate: cover property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
        $fell(CP_CLK_GATE_O) && $fell(AMP_HOLD_O));
    c_cal: cover property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
        cal_ff && $rose(AMP_HOLD_O));
endmodule : amp_offset_autozero_ctrl

`default_nettype wire

// File: sim/mcu_sync_model.sv
// Purpose: Controller model driving the gain/sync pin
// Assumes: One clock shared with the block
// Notes: Pin idles low, pulse length set by HI_CYC
`timescale 1ns/10ps
`default_nettype none
module mcu_sync_model #(
    parameter int HI_CYC = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic fire_i,
    output logic sync_o
);
    int cnt_ff;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_o <= 1'b0;
            cnt_ff <= 0;
        end else if (fire_i) begin
            sync_o <= 1'b1;
            cnt_ff <= HI_CYC;
        end else if (cnt_ff > 1) begin
            cnt_ff <= cnt_ff - 1;
        end else if (cnt_ff == 1) begin
            sync_o <= 1'b0;
            cnt_ff <= 0;
        end
    end
endmodule : mcu_sync_model
`default_nettype wire

// File: sim/amp_offset_autozero_ctrl_bench.sv
// Purpose: Self-checking bench for the auto-zero controller
// Assumes: Shortened timing parameters
// Notes: Sync pin comes from the controller model
`timescale 1ns/10ps
`default_nettype none
module amp_offset_autozero_ctrl_bench;
    localparam int SPC = 4;
    localparam int NRM = 8;
    localparam int DUR = 3;
    localparam int TO = 16;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic drv_en = 1'b1;
    logic act = 1'b1;
    logic stby = 1'b0;
    logic cp_ok = 1'b1;
    logic [2:0] gate = 3'h0;
    logic ls_uv = 1'b0;
    logic hs_uv = 1'b0;
    logic fire = 1'b0;
    logic [31:0] rdata;
    logic sync, short_o, hold, cp_gate, uv;
    logic [31:0] d;
    int err_count = 0;
    int cmp_count = 0;
    int n;
    amp_offset_autozero_ctrl #(.SPC_CYC(SPC), .NORM_CYC(NRM), .DUR_CYC(DUR), .TOUT_CYC(TO))
    u_amp_offset_autozero_ctrl (.CLK_SYS_I(clk), .RESETN_I(rstn), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .DRIVE_EN_I(drv_en),
        .STATE_ACTIVE_I(act), .STATE_STANDBY_I(stby), .CP_UV_OK_I(cp_ok), .GATE_HS_I(gate),
        .SYNC_PIN_I(sync), .LS_RAIL_UV_I(ls_uv), .HS_RAIL_UV_I(hs_uv), .AMP_SHORT_O(short_o),
        .AMP_HOLD_O(hold), .CP_CLK_GATE_O(cp_gate), .UV_FAULT_O(uv));
    mcu_sync_model u_mcu_sync_model (.clk_i(clk), .rst_n_i(rstn), .fire_i(fire), .sync_o(sync));
    always #25 clk = ~clk;
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic tally_and_finish;
        if (err_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_rng(input int got, input int lo, input int hi);
        cmp_count++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h..%h", $time, got, lo, hi);
        end
    endtask : chk_rng
    task automatic tick(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : tick
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask : rd_reg
    task automatic gate_pulse;
        @(posedge clk);
        gate <= 3'h2;
        @(posedge clk);
        gate <= 3'h0;
    endtask : gate_pulse
    // Seek hold at level v, then count cycles it stays there
    task automatic meas(input logic v, input int bound, output int k);
        k = 0;
        while (hold !== v && k < bound) begin
            tick(1);
            k++;
        end
        if (hold !== v) begin
            err_count++;
            tally_and_finish;
        end
        k = 0;
        while (hold === v && k < bound) begin
            tick(1);
            k++;
        end
    endtask : meas
    task automatic no_hold(input int c);
        int h = 0;
        repeat (c) begin
            tick(1);
            if (hold === 1'b1) h++;
        end
        chk(h, 0);
    endtask : no_hold
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic sc_reset_bus;
        tick(1);
        chk({short_o, hold, cp_gate, uv}, 32'h0);
        rd_reg(4'h0, d);
        chk(d, 32'h0);
        rd_reg(4'h8, d);
        chk(d, 32'h0);
        wr_reg(4'h8, 32'hf);
        rd_reg(4'h0, d);
        chk(d, 32'h0);
    endtask : sc_reset_bus
    task automatic sc_internal;
        meas(1'b1, TO * 3, n);
        chk(n, DUR);
        gate_pulse;
        no_hold(3);
        gate_pulse;
        tick(1);
        chk(hold, 1'b1);
        chk(short_o, 1'b1);
        meas(1'b1, 8, n);
        meas(1'b0, TO * 2, n);
        chk_rng(n, TO, TO + 2);
    endtask : sc_internal
    task automatic sc_cal;
        act <= 1'b0;
        wr_reg(4'h0, 32'h1);
        rd_reg(4'h0, d);
        chk(d, 32'h0);
        act <= 1'b1;
        wr_reg(4'h0, 32'h1);
        tick(1);
        chk(short_o, 1'b1);
        rd_reg(4'h4, d);
        chk(d & 32'h1, 32'h1);
        meas(1'b1, TO * 2, n);
        meas(1'b0, TO * 2, n);
        chk_rng(n, SPC, SPC + 2);
        meas(1'b1, 8, n);
        chk(short_o, 1'b1);
        wr_reg(4'h0, 32'h0);
        tick(1);
        chk(short_o, 1'b0);
    endtask : sc_cal
    task automatic sc_dis;
        wr_reg(4'h0, 32'h2);
        no_hold(TO * 3);
        ls_uv <= 1'b1;
        tick(2);
        chk(uv, 1'b1);
        rd_reg(4'h4, d);
        chk(d & 32'h8, 32'h8);
        ls_uv <= 1'b0;
    endtask : sc_dis
    task automatic sc_start;
        wr_reg(4'h0, 32'h0);
        act <= 1'b0;
        cp_ok <= 1'b0;
        meas(1'b1, TO * 3, n);
        meas(1'b0, TO * 2, n);
        chk_rng(n, NRM, NRM + 2);
        cp_ok <= 1'b1;
        meas(1'b1, 8, n);
        no_hold(TO * 2);
        stby <= 1'b1;
        meas(1'b0, TO * 3, n);
        chk(hold, 1'b1);
        meas(1'b1, 8, n);
        stby <= 1'b0;
        act <= 1'b1;
    endtask : sc_start
    task automatic sc_ext;
        wr_reg(4'h0, 32'hc);
        tick(SPC + 1);
        gate_pulse;
        no_hold(4);
        @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        tick(2);
        chk({cp_gate, hold}, 32'h2);
        hs_uv <= 1'b1;
        tick(2);
        chk(uv, 1'b1);
        hs_uv <= 1'b0;
        meas(1'b0, 12, n);
        chk(cp_gate, 1'b1);
        meas(1'b1, 8, n);
        chk(n, DUR);
        chk(cp_gate, 1'b0);
    endtask : sc_ext
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        sc_reset_bus;
        sc_internal;
        sc_cal;
        sc_dis;
        sc_start;
        sc_ext;
        tally_and_finish;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        tally_and_finish;
    end
endmodule : amp_offset_autozero_ctrl_bench
`default_nettype wire
